/* File: hw/stp_params.svh */
`ifndef STP_PARAMS_SVH
`define STP_PARAMS_SVH
// ****************
// Register map
// ****************
`define STP_OFS_CTRL 4'h0
`define STP_OFS_STATUS 4'h4
`define STP_CTRL_RESET 8'h12
`define STP_CB_DOUBLE 0
`define STP_CB_ENC 1
`define STP_CB_XAUI 2
`define STP_CB_GEOFF 3
`define STP_CB_USED 4
`define STP_CB_REFLO 5
`define STP_CB_REFHI 6
`define STP_CB_RAW10 7
// ****************
// Timing and depth
// ****************
`define STP_FIFO_DEPTH 4
`define STP_LOCK_TOGGLES 5'h10
`define STP_LOSS_CYCLES 7'h40
`define STP_ALIGN_BASE 5'h10
`define STP_PRBS_SEED 7'h7f
// ****************
// Characters
// ****************
`define STP_K285 8'hbc
`define STP_K280 8'h1c
`define STP_K283 8'h7c
`define STP_K307 8'hfe
`define STP_D56 8'hc5
`define STP_D162 8'h50
`define STP_D215 8'hb5
`define STP_D22 8'h42
`define STP_XG_IDLE 8'h07
`define STP_XG_SEQ 8'h9c
`define STP_XG_START 8'hfb
`define STP_XG_TERM 8'hfd
`define STP_FILL_RAW 10'h2aa
`endif

/* File: hw/stp_pkg.sv */
package stp_pkg;
  typedef enum logic [1:0] {
    STP_GE_PASS = 2'b01,
    STP_GE_COMMA = 2'b10
  } stp_ge_state_type;
endpackage : stp_pkg

/* File: hw/stp_tx_path.sv */
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Make bit tick, reference word tick, fabric tick halved in double mode.
// - One reference input chosen from dedicated pin, fabric or neighbour line.
// - Clock generator may be switched off when no channel is used.
// - Lock output shows the generator is locked to its reference.
// - Four-word phase compensation FIFO between fabric and link, never bypassed.
// - Double mode splits each 16/20-bit word into two 8/10-bit words.
// - Single mode skips the byte serializer, words pass straight through.
// - 8b/10b maps byte plus control flag; run length never above five.
// - Encoder can be bypassed, raw words then go to the serializer.
// - State machine runs Gigabit Ethernet or XAUI mode, one at a time.
// - Ethernet idles become I1 (K28.5-, D5.6) or I2 (K28.5+, D16.2-).
// - Idle choice leaves running disparity negative after every set.
// - Configuration sets pass unchanged, never produced by idle conversion.
// - Ethernet state machine has a static disable, even in Ethernet mode.
// - XAUI maps data, 07 idle, 9C, FB, FD, FE; others become K30.7.
// - XAUI idles K28.0/K28.5 picked by PRBS x^7+x^6+1.
// - XAUI inserts K28.3 after 16 to 31 idle code groups.
// - Serializer sends each 8 or 10-bit word least significant bit first.
`include "stp_params.svh"
module stp_tx_path
  import stp_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [19:0] txData,
  input wire logic [1:0] txCtrl,
  input wire logic txValid,
  output logic txReady,
  output logic fabricTick,
  output logic refWordTick,
  output logic serialBitTick,
  input wire logic dedicatedRefClockPin,
  input wire logic refFabric,
  input wire logic refInterXcvr,
  output logic pllLocked,
  output logic serialOut
);
  // ****************
  // 8b/10b encoder
  // ****************
  function automatic logic [10:0] enc10(input logic [7:0] d,
                                        input logic k,
                                        input logic rd);
    logic [5:0] s;
    logic [3:0] f;
    logic r;
    logic alt;
    logic [9:0] seq;
    logic [9:0] q;
    unique case (d[4:0])
      5'd0: s = 6'b100111;  5'd1: s = 6'b011101;
      5'd2: s = 6'b101101;  5'd3: s = 6'b110001;
      5'd4: s = 6'b110101;  5'd5: s = 6'b101001;
      5'd6: s = 6'b011001;  5'd7: s = 6'b111000;
      5'd8: s = 6'b111001;  5'd9: s = 6'b100101;
      5'd10: s = 6'b010101; 5'd11: s = 6'b110100;
      5'd12: s = 6'b001101; 5'd13: s = 6'b101100;
      5'd14: s = 6'b011100; 5'd15: s = 6'b010111;
      5'd16: s = 6'b011011; 5'd17: s = 6'b100011;
      5'd18: s = 6'b010011; 5'd19: s = 6'b110010;
      5'd20: s = 6'b001011; 5'd21: s = 6'b101010;
      5'd22: s = 6'b011010; 5'd23: s = 6'b111010;
      5'd24: s = 6'b110011; 5'd25: s = 6'b100110;
      5'd26: s = 6'b010110; 5'd27: s = 6'b110110;
      5'd28: s = k ? 6'b001111 : 6'b001110;
      5'd29: s = 6'b101110; 5'd30: s = 6'b011110;
      default: s = 6'b101011;
    endcase
    r = rd;
    if (s == 6'b111000) begin
      if (rd) s = 6'b000111;
    end else if ($countones(s) != 3) begin
      if (rd) s = ~s;
      r = ~rd;
    end
    alt = k || (!r && (d[4:0] == 5'd17 || d[4:0] == 5'd18 ||
                       d[4:0] == 5'd20)) ||
          (r && (d[4:0] == 5'd11 || d[4:0] == 5'd13 ||
                 d[4:0] == 5'd14));
    unique case (d[7:5])
      3'd0: f = 4'b1011; 3'd1: f = 4'b1001;
      3'd2: f = 4'b0101; 3'd3: f = 4'b1100;
      3'd4: f = 4'b1101; 3'd5: f = 4'b1010;
      3'd6: f = 4'b0110;
      default: f = alt ? 4'b0111 : 4'b1110;
    endcase
    if (f == 4'b1100) begin
      if (r) f = 4'b0011;
    end else if ($countones(f) != 2) begin
      if (r) f = ~f;
      r = ~r;
    end else if (k && d[4:0] == 5'd28 && !r) begin
      f = ~f;
    end
    seq = {s, f};
    for (int i = 0; i < 10; i++) q[i] = seq[9-i];
    return {r, q};
  endfunction : enc10

  // ****************
  // Configuration and reference lock
  // ****************
  logic [7:0] ctrl_reg;
  logic isDouble, encOn, isXaui, geOff, txUsed, raw10;
  logic [1:0] refSel;
  assign isDouble = ctrl_reg[`STP_CB_DOUBLE];
  assign encOn = ctrl_reg[`STP_CB_ENC];
  assign isXaui = ctrl_reg[`STP_CB_XAUI];
  assign geOff = ctrl_reg[`STP_CB_GEOFF];
  assign txUsed = ctrl_reg[`STP_CB_USED];
  assign refSel = ctrl_reg[`STP_CB_REFHI:`STP_CB_REFLO];
  assign raw10 = ctrl_reg[`STP_CB_RAW10];

  logic refIn, refPrev_reg, refToggle, run;
  logic [4:0] lockCnt_reg;
  logic [6:0] quietCnt_reg;
  logic [1:0] refSelPrev_reg;
  always_comb begin
    unique case (refSel)
      2'd0: refIn = dedicatedRefClockPin;
      2'd1: refIn = refFabric;
      default: refIn = refInterXcvr;
    endcase
  end
  assign refToggle = refIn != refPrev_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      refPrev_reg <= 1'b0;
      refSelPrev_reg <= 2'h0;
      lockCnt_reg <= 5'h0;
      quietCnt_reg <= 7'h0;
      pllLocked <= 1'b0;
    end else begin
      refPrev_reg <= refIn;
      refSelPrev_reg <= refSel;
      // Switched off or reselected: lock is lost at once
      if (!txUsed || refSel != refSelPrev_reg) begin
        lockCnt_reg <= 5'h0;
        quietCnt_reg <= 7'h0;
        pllLocked <= 1'b0;
      end else if (refToggle) begin
        quietCnt_reg <= 7'h0;
        if (lockCnt_reg == `STP_LOCK_TOGGLES - 5'h1) pllLocked <= 1'b1;
        else lockCnt_reg <= lockCnt_reg + 5'h1;
      end else if (quietCnt_reg == `STP_LOSS_CYCLES - 7'h1) begin
        lockCnt_reg <= 5'h0;
        pllLocked <= 1'b0;
      end else begin
        quietCnt_reg <= quietCnt_reg + 7'h1;
      end
    end
  end
  assign run = txUsed && pllLocked;

  // ****************
  // Phase compensation FIFO
  // ****************
  logic [21:0] fifoMem [`STP_FIFO_DEPTH];
  logic [1:0] wrPtr_reg, rdPtr_reg;
  logic [2:0] level_reg;
  logic push, pop, empty, load;
  logic [21:0] head;
  // Fabric side relies on a frequency-locked clock, so no resync here
  assign txReady = level_reg != 3'(`STP_FIFO_DEPTH);
  assign push = txValid && txReady;
  assign empty = level_reg == 3'h0;
  assign head = fifoMem[rdPtr_reg];

  always_ff @(posedge clk) begin
    if (push) fifoMem[wrPtr_reg] <= {txCtrl, txData};
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_reg <= 2'h0;
      rdPtr_reg <= 2'h0;
      level_reg <= 3'h0;
    end else begin
      if (push) wrPtr_reg <= wrPtr_reg + 2'h1;
      if (pop) rdPtr_reg <= rdPtr_reg + 2'h1;
      level_reg <= level_reg + 3'(push) - 3'(pop);
    end
  end

  // ****************
  // Byte serializer
  // ****************
  logic upper_reg;
  logic [9:0] half;
  logic halfK;
  logic [7:0] underflow_reg;
  assign half = upper_reg ? head[19:10] : head[9:0];
  assign halfK = upper_reg ? head[21] : head[20];
  // Single mode pops every word; double mode only in the load of the upper half
  assign pop = load && !empty && (!isDouble || upper_reg);
  assign fabricTick = pop;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upper_reg <= 1'b0;
      underflow_reg <= 8'h0;
    end else begin
      if (!isDouble) upper_reg <= 1'b0;
      else if (load && !empty) upper_reg <= !upper_reg;
      if (load && empty && underflow_reg != 8'hff)
        underflow_reg <= underflow_reg + 8'h1;
    end
  end

  // ****************
  // Transmit state machine
  // ****************
  stp_ge_state_type geState_reg, geState_next;
  logic [6:0] prbs_reg;
  logic [4:0] alignCnt_reg;
  logic [7:0] inByte, smByte;
  logic inK, smK, xIdle, rd_reg;
  assign inByte = empty ? (isXaui ? `STP_XG_IDLE : `STP_K285) : half[7:0];
  assign inK = empty ? 1'b1 : halfK;
  assign xIdle = isXaui && inK && inByte == `STP_XG_IDLE;

  always_comb begin
    smByte = inByte;
    smK = inK;
    geState_next = geState_reg;
    if (isXaui) begin
      if (inK) begin
        unique case (inByte)
          `STP_XG_IDLE: smByte = alignCnt_reg == 5'h0 ? `STP_K283 :
                                 (prbs_reg[0] ? `STP_K285 : `STP_K280);
          `STP_XG_SEQ, `STP_XG_START, `STP_XG_TERM, `STP_K307: ;
          default: smByte = `STP_K307;
        endcase
      end
    end else if (!geOff) begin
      unique case (geState_reg)
        STP_GE_PASS: begin
          if (inK && inByte == `STP_K285) geState_next = STP_GE_COMMA;
        end
        STP_GE_COMMA: begin
          if (!(inK && inByte == `STP_K285)) geState_next = STP_GE_PASS;
          // Only data other than a configuration set is an idle
          if (!inK && inByte != `STP_D215 && inByte != `STP_D22)
            smByte = rd_reg ? `STP_D162 : `STP_D56;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      geState_reg <= STP_GE_PASS;
      prbs_reg <= `STP_PRBS_SEED;
      alignCnt_reg <= `STP_ALIGN_BASE;
    end else if (load) begin
      geState_reg <= (isXaui || geOff) ? STP_GE_PASS : geState_next;
      if (xIdle) begin
        prbs_reg <= {prbs_reg[5:0], prbs_reg[6] ^ prbs_reg[5]};
        if (alignCnt_reg == 5'h0)
          alignCnt_reg <= `STP_ALIGN_BASE | {1'b0, prbs_reg[3:0]};
        else alignCnt_reg <= alignCnt_reg - 5'h1;
      end
    end
  end

  // ****************
  // Encoder and serializer
  // ****************
  logic [10:0] encOut;
  logic [9:0] word;
  logic [9:0] shift_reg;
  logic [3:0] bitCnt_reg;
  logic wide;
  assign encOut = enc10(smByte, smK, rd_reg);
  assign wide = encOn || raw10;
  always_comb begin
    if (encOn) word = encOut[9:0];
    else if (empty) word = `STP_FILL_RAW;
    else word = raw10 ? half : {2'b00, half[7:0]};
  end
  assign load = run && bitCnt_reg == 4'h0;
  assign refWordTick = load;
  assign serialBitTick = run;
  assign serialOut = shift_reg[0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= 10'h0;
      bitCnt_reg <= 4'h0;
      rd_reg <= 1'b0;
    end else if (load) begin
      shift_reg <= word;
      bitCnt_reg <= wide ? 4'h9 : 4'h7;
      if (encOn) rd_reg <= encOut[10];
    end else if (run) begin
      shift_reg <= {1'b0, shift_reg[9:1]};
      bitCnt_reg <= bitCnt_reg - 4'h1;
    end
  end

  // ****************
  // AXI4-Lite slave
  // ****************
  logic awHeld_reg, wHeld_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic wLane0_reg;
  assign awready = !awHeld_reg;
  assign wready = !wHeld_reg;
  assign arready = !rvalid;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= 32'h0;
      wLane0_reg <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      ctrl_reg <= `STP_CTRL_RESET;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wLane0_reg <= wstrb[0];
      end
      if (bvalid && bready) bvalid <= 1'b0;
      if (awHeld_reg && wHeld_reg && !bvalid) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= 2'h0;
        if (awAddr_reg == `STP_OFS_CTRL) begin
          if (wLane0_reg) ctrl_reg <= wData_reg[7:0];
        end else if (awAddr_reg != `STP_OFS_STATUS) begin
          bresp <= 2'h2;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= 2'h0;
      if (araddr == `STP_OFS_CTRL) rdata <= {24'h0, ctrl_reg};
      else if (araddr == `STP_OFS_STATUS)
        rdata <= {16'h0, underflow_reg, 2'h0,
                  geState_reg == STP_GE_COMMA, rd_reg, level_reg, pllLocked};
      else begin
        rdata <= 32'h0;
        rresp <= 2'h2;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************
  // Checks
  // ****************
  logic [2:0] runLen_reg;
  logic lastBit_reg;
  logic [5:0] idleGap_reg;
  logic seenAlign_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      runLen_reg <= 3'h0;
      lastBit_reg <= 1'b0;
      idleGap_reg <= 6'h0;
      seenAlign_reg <= 1'b0;
    end else begin
      if (run) begin
        lastBit_reg <= serialOut;
        runLen_reg <= (serialOut == lastBit_reg && runLen_reg != 3'h7) ?
                      runLen_reg + 3'h1 : 3'h1;
      end else runLen_reg <= 3'h0;
      if (load && xIdle) begin
        if (smByte == `STP_K283) begin
          idleGap_reg <= 6'h0;
          seenAlign_reg <= 1'b1;
        end else if (idleGap_reg != 6'h3f) idleGap_reg <= idleGap_reg + 6'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_fifo_bound: assert property (level_reg <= 3'(`STP_FIFO_DEPTH))
    else $error("fifo holds more than four words");
  a_full_refuse: assert property (level_reg == 3'h4 |-> !txReady)
    else $error("fifo accepts while full");
  a_run_limit: assert property (encOn && run |-> runLen_reg <= 3'h5)
    else $error("run of more than five equal bits");
  a_ge_negative: assert property (load && !isXaui && !geOff && encOn &&
    geState_reg == STP_GE_COMMA && !inK && inByte != `STP_D215 &&
    inByte != `STP_D22 |=> !rd_reg)
    else $error("disparity not negative after idle set");
  a_cfg_kept: assert property (load && !isXaui &&
    !inK && (inByte == `STP_D215 || inByte == `STP_D22)
    |-> smByte == inByte)
    else $error("configuration set altered");
  a_xaui_badctl: assert property (load && isXaui && inK &&
    !(inByte inside {`STP_XG_IDLE, `STP_XG_SEQ, `STP_XG_START,
    `STP_XG_TERM, `STP_K307}) |-> smByte == `STP_K307)
    else $error("invalid control not mapped to error code");
  a_align_gap: assert property (load && xIdle && smByte == `STP_K283 &&
    seenAlign_reg |-> idleGap_reg >= 6'h10 && idleGap_reg <= 6'h1f)
    else $error("alignment spacing out of range");
  a_lsb_first: assert property (load |=> serialOut == $past(word[0])
    ##1 (!run || serialOut == $past(word[1], 2)))
    else $error("serial order not lsb first");
  a_lower_first: assert property (pop && isDouble |->
    upper_reg && half == head[19:10])
    else $error("upper half sent before lower half");
  a_off_unlock: assert property (!txUsed |=> !pllLocked ##1 !refWordTick)
    else $error("generator running while switched off");
  a_single_pass: assert property (load && !isDouble && !empty |->
    pop && fabricTick)
    else $error("single mode word not passed through");

  c_double: cover property (pop && isDouble);
  c_ge_idle: cover property (load && geState_reg == STP_GE_COMMA && !inK);
  c_xaui_align: cover property (load && xIdle && smByte == `STP_K283);
  c_fifo_full: cover property (level_reg == 3'h4);
endmodule : stp_tx_path

/* File: verification/stp_fabric_model.sv */
`timescale 1ns/1ps
// ********
// Fabric user logic feeding parallel words
// ********
module stp_fabric_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic txReady,
  output logic [19:0] txData,
  output logic [1:0] txCtrl,
  output logic txValid
);
  logic [21:0] wordQ[$];
  logic slow;
  initial begin
    slow = 1'b0;
    txData = 20'h0;
    txCtrl = 2'h0;
    txValid = 1'b0;
  end
  task automatic send(input logic [19:0] d, input logic [1:0] c);
    wordQ.push_back({c, d});
  endtask : send
  // Same clock as the block, so the phase offset stays under one cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txValid <= 1'b0;
    end else if (!txValid || txReady) begin
      if (wordQ.size() > 0 && !(slow && txValid)) begin
        {txCtrl, txData} <= wordQ.pop_front();
        txValid <= 1'b1;
      end else begin
        // Idle bus moves every cycle, never a stale word
        {txCtrl, txData} <= ~{txCtrl, txData};
        txValid <= 1'b0;
      end
    end
  end
endmodule : stp_fabric_model

/* File: verification/test_stp_tx_path.sv */
`timescale 1ns/1ps
module test_stp_tx_path import stp_pkg::*;;
  // ********
  // Signals
  // ********
  logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, txValid, txReady, fabricTick;
  logic refWordTick, serialBitTick, dedicatedRefClockPin, refFabric;
  logic refInterXcvr, pllLocked, serialOut, encOn, refRun, lastBit;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, txCtrl;
  logic [19:0] txData;
  int n_errors, compares, runLen, ticks;

  stp_tx_path dut_u (.clk, .resetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .txData, .txCtrl, .txValid,
    .txReady, .fabricTick, .refWordTick, .serialBitTick,
    .dedicatedRefClockPin, .refFabric, .refInterXcvr, .pllLocked,
    .serialOut);
  stp_fabric_model fab_u (.clk, .resetn, .txReady, .txData, .txCtrl,
    .txValid);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (refRun) dedicatedRefClockPin <= ~dedicatedRefClockPin;
  end
  always @(negedge clk) begin
    if (fabricTick === 1'b1) ticks++;
  end
  always @(negedge clk) begin
    if (serialBitTick === 1'b1 && encOn) begin
      runLen = (serialOut === lastBit) ? runLen + 1 : 1;
      lastBit = serialOut;
      if (runLen > 5) chk("run_length", 32'(runLen), 32'd5);
    end else begin
      runLen = 0;
    end
  end
  // ********
  // Shared tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Ready is sampled at the falling edge so a comb answer is never raced
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic ta, tw, tb;
    int k;
    k = 0;
    tb = 1'b0;
    r = 2'h3;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb && k < 200) begin
      @(negedge clk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      k++;
    end
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ta, tr;
    int k;
    k = 0;
    tr = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr && k < 200) begin
      @(negedge clk);
      ta = arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      k++;
    end
    rready <= 1'b0;
  endtask : axi_rd
  // Bit i of the result is the i-th bit on the line
  task automatic get_sym(output logic [9:0] v);
    int k;
    k = 0;
    if (clk === 1'b1) @(negedge clk);
    while (refWordTick !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      v[i] = serialOut;
    end
  endtask : get_sym
  function automatic bit is_fill(input logic [9:0] v, input int m);
    case (m)
      0: return v === 10'h2aa;
      1: return v === 10'h17c || v === 10'h283;
      default: return v inside {10'h17c, 10'h283, 10'h0bc, 10'h343,
                                10'h33c, 10'h0c3};
    endcase
  endfunction : is_fill
  task automatic next_data(input int m, output logic [9:0] v,
                           output logic [9:0] p);
    int k;
    k = 0;
    p = 10'h0;
    get_sym(v);
    while (is_fill(v, m) && k < 300) begin
      p = v;
      get_sym(v);
      k++;
    end
  endtask : next_data
  // ********
  // Scenarios
  // ********
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(4'h0, d, r);
    chk("ctrl_reset", d, 32'h12);
    axi_rd(4'h4, d, r);
    chk("status_reset", {28'h0, d[3:0]}, 32'h0);
    axi_wr(4'h8, 32'hff, r);
    chk("bad_wr_resp", 32'(r), 32'h2);
    axi_rd(4'hc, d, r);
    chk("bad_rd", {d[29:0], r}, 32'h2);
    axi_wr(4'h4, 32'h0, r);
    chk("status_wr", 32'(r), 32'h0);
  endtask : t_regs
  task automatic t_fill();
    logic [9:0] w[5] = '{10'h301, 10'h0f2, 10'h1c4, 10'h088, 10'h3e5};
    logic [9:0] v, p;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(4'h0, 32'h90, r);
    for (int i = 0; i < 5; i++) fab_u.send({10'h0, w[i]}, 2'b00);
    repeat (12) @(posedge clk);
    chk("ready_full", 32'(txReady), 32'h0);
    axi_rd(4'h4, d, r);
    chk("level_full", {28'h0, d[3:0]}, 32'h8);
    refRun <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      next_data(0, v, p);
      chk("single_word", 32'(v), 32'(w[i]));
    end
    chk("locked", 32'(pllLocked), 32'h1);
    chk("fabric_ticks", 32'(ticks), 32'd5);
  endtask : t_fill
  task automatic t_double();
    logic [9:0] v, p;
    logic [1:0] r;
    axi_wr(4'h0, 32'h91, r);
    fab_u.slow = 1'b1;
    fab_u.send({10'h2c3, 10'h13a}, 2'b00);
    fab_u.send({10'h05d, 10'h3b6}, 2'b00);
    next_data(0, v, p);
    chk("dbl_lo0", 32'(v), 32'h13a);
    get_sym(v);
    chk("dbl_hi0", 32'(v), 32'h2c3);
    next_data(0, v, p);
    chk("dbl_lo1", 32'(v), 32'h3b6);
    get_sym(v);
    chk("dbl_hi1", 32'(v), 32'h05d);
  endtask : t_double
  // eA follows a comma that ended negative, eB one that ended positive
  task automatic ge_pair(input logic [7:0] cv, input logic [7:0] b,
                         input logic [9:0] eA, input logic [9:0] eB);
    logic [9:0] v, p;
    logic [1:0] r;
    axi_wr(4'h0, {24'h0, cv}, r);
    fab_u.send(20'hbc, 2'b01);
    fab_u.send({12'h0, b}, 2'b00);
    next_data(1, v, p);
    chk("ge_second", 32'(v), 32'(p === 10'h283 ? eA : eB));
  endtask : ge_pair
  task automatic t_ge();
    encOn = 1'b1;
    ge_pair(8'h12, 8'h00, 10'h1a5, 10'h289);
    ge_pair(8'h12, 8'hb5, 10'h155, 10'h155);
    ge_pair(8'h12, 8'h42, 10'h2ad, 10'h292);
    ge_pair(8'h1a, 8'h00, 10'h0b9, 10'h346);
  endtask : t_ge
  task automatic t_xaui();
    logic [9:0] v, p;
    logic [1:0] r;
    int gap;
    bit seen;
    gap = 0;
    seen = 1'b0;
    axi_wr(4'h0, 32'h16, r);
    for (int i = 0; i < 80; i++) begin
      get_sym(v);
      chk("xaui_idle", 32'(is_fill(v, 2)), 32'h1);
      if (v === 10'h33c || v === 10'h0c3) begin
        if (seen) begin
          chk("align_gap", 32'(gap >= 16 && gap <= 31), 32'h1);
        end
        seen = 1'b1;
        gap = 0;
      end else begin
        gap++;
      end
    end
    fab_u.send(20'hfb, 2'b01);
    fab_u.send(20'h42, 2'b01);
    next_data(2, v, p);
    chk("x_start", 32'(v === 10'h05b || v === 10'h3a4), 32'h1);
    next_data(2, v, p);
    chk("x_other", 32'(v === 10'h05e || v === 10'h3a1), 32'h1);
  endtask : t_xaui
  // Channel off, then a silent reference, then back to the pin
  task automatic t_off();
    logic [1:0] r;
    axi_wr(4'h0, 32'h06, r);
    repeat (3) @(negedge clk);
    chk("off_lock", 32'(pllLocked), 32'h0);
    chk("off_tick", 32'(serialBitTick), 32'h0);
    axi_wr(4'h0, 32'h36, r);
    repeat (40) @(negedge clk);
    chk("fabric_ref_lock", 32'(pllLocked), 32'h0);
    axi_wr(4'h0, 32'h16, r);
    repeat (40) @(negedge clk);
    chk("pin_ref_lock", 32'(pllLocked), 32'h1);
  endtask : t_off
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // ********
  // Main sequence and watchdog
  // ********
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {dedicatedRefClockPin, refFabric, refInterXcvr} = 3'h0;
    {encOn, refRun, lastBit} = 3'h0;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'hf;
    {n_errors, compares, runLen, ticks} = '0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_fill();
    t_double();
    t_ge();
    t_xaui();
    t_off();
    end_sim();
  end
  initial begin
    #500000;
    n_errors++;
    end_sim();
  end
endmodule : test_stp_tx_path
